// ---- design/brake_alarm_seq.sv ----
// Brake interlock and alarm sequencer with APB configuration
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module brake_alarm_seq #(
    parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
    input wire logic clock,                 // 125 MHz system clock
    input wire logic arst_n,                // Asynchronous reset
    input wire logic psel,                  // APB select
    input wire logic penable,               // APB enable
    input wire logic pwrite,                // APB write
    input wire logic [7:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,         // APB write data
    output logic [31:0] prdata,             // APB read data
    output logic pready,                    // APB ready
    output logic pslverr,                   // APB error
    input wire logic servo_on_n,            // Servo-on pin, low = on
    input wire logic alarm_clear_in,        // Alarm clear pin, high = on
    input wire logic [13:0] motor_speed,    // Speed magnitude, per min
    input wire logic alarm_detect,          // Alarm event pulse
    input wire logic [2:0] alarm_type,      // Code of detected alarm
    input wire logic alarm_is_encoder,      // Alarm is encoder class
    input wire logic [2:0] other_out_on,    // Other signals per circuit
    output logic motor_power_on,            // Power stage enable
    output logic brake_interlock_out,       // Low releases the brake
    output logic [2:0] out_circuit_n,       // Output circuits, low closed
    output logic alarm_status_out,          // High while alarmed
    output logic alarm_code_bit0,           // Alarm code bit 0
    output logic alarm_code_bit1,           // Alarm code bit 1
    output logic alarm_code_bit2            // Alarm code bit 2
);
    // All sequencer, alarm and register state
    typedef struct packed {
        brake_seq_pkg::seq_state_t st;      // Sequencer state
        logic [6:0] ticks;                  // Ticks since sequence start
        logic motor_on;                     // Power stage enabled
        logic brake_rel;                    // Brake released
        logic [2:0] circ_n;                 // Output circuit levels
        logic alarm;                        // Alarm latched
        logic encoder;                      // Latched alarm is encoder
        logic [2:0] code;                   // Latched alarm code
        logic clr_prev;                     // Clear level, last cycle
        logic [1:0] sel;                    // Brake output select
        logic [5:0] delay;                  // Standstill delay
        logic [13:0] level;                 // Running speed level
        logic [6:0] timeout;                // Running timeout
        logic [13:0] max_speed;             // Motor maximum speed
        logic [31:0] rdata;                 // Registered read data
        logic err;                          // Registered slave error
    } seq_regs_t;

    seq_regs_t s_reg;
    seq_regs_t s_next;
    logic [1:0] pins_sync;                  // Synchronised pins
    logic son;                              // Servo-on requested
    logic clr_level;                        // Clear pin active
    logic tick;                             // 10 ms tick
    logic restart;                          // Realign time base
    logic [13:0] lvl_eff;                   // Effective speed level
    logic stopped;                          // Motor counts as stopped
    logic clr_edge;                         // Clear pin rising edge
    logic wr;                               // APB write access
    logic [6:0] ticks_inc;                  // Tick count plus one

    // Pins cross into the clock domain; servo-on idles off
    sync2 #(.W(2), .RESET_VAL(2'h1)) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d({alarm_clear_in, servo_on_n}),
        .q(pins_sync)
    );

    // Time base realigned whenever a timed sequence starts
    tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .restart(restart),
        .tick(tick)
    );

    assign son = ~pins_sync[0];
    assign clr_level = pins_sync[1];
    assign clr_edge = clr_level & ~s_reg.clr_prev;
    // Level above the maximum speed is cut to it
    assign lvl_eff = (s_reg.level > s_reg.max_speed) ?
        s_reg.max_speed : s_reg.level;
    assign stopped = motor_speed < lvl_eff;
    assign restart = (s_reg.st != s_next.st);
    assign ticks_inc = s_reg.ticks + 7'h01;
    assign wr = psel & penable & pwrite;

    // Sequencer, alarm latch and register file next state
    always_comb begin
        s_next = s_reg;
        s_next.clr_prev = clr_level;
        s_next.rdata = 32'h0000_0000;
        s_next.err = 1'b0;
        if (tick) begin
            s_next.ticks = ticks_inc;
        end
        // Clear first, so a new alarm in the same cycle wins
        if (clr_edge && !s_reg.encoder) begin
            s_next.alarm = 1'b0;
        end
        if (alarm_detect && !s_next.alarm) begin
            s_next.alarm = 1'b1;
            s_next.code = alarm_type;
            s_next.encoder = alarm_is_encoder;
        end else if (alarm_detect) begin
            s_next.encoder = s_reg.encoder | alarm_is_encoder;
        end
        case (s_reg.st)
            brake_seq_pkg::ST_OFF: begin
                // Power up and release the brake together
                if (son && !s_reg.alarm && !alarm_detect) begin
                    s_next.st = brake_seq_pkg::ST_ON;
                    s_next.motor_on = 1'b1;
                    s_next.brake_rel = 1'b1;
                end
            end
            brake_seq_pkg::ST_ON: begin
                s_next.ticks = 7'h00;
                if (alarm_detect || s_reg.alarm) begin
                    s_next.motor_on = 1'b0;
                    if (stopped) begin
                        s_next.brake_rel = 1'b0;
                        s_next.st = brake_seq_pkg::ST_OFF;
                    end else begin
                        s_next.st = brake_seq_pkg::ST_RUN_WAIT;
                    end
                end else if (!son) begin
                    if (!stopped) begin
                        s_next.motor_on = 1'b0;
                        s_next.st = brake_seq_pkg::ST_RUN_WAIT;
                    end else if (s_reg.delay == 6'h00) begin
                        s_next.motor_on = 1'b0;
                        s_next.brake_rel = 1'b0;
                        s_next.st = brake_seq_pkg::ST_OFF;
                    end else begin
                        s_next.brake_rel = 1'b0;
                        s_next.st = brake_seq_pkg::ST_STAND_WAIT;
                    end
                end
            end
            brake_seq_pkg::ST_STAND_WAIT: begin
                // Brake applied, motor held until the delay runs out or an alarm is detected
                if (alarm_detect ||
                    (tick && ticks_inc >= {1'b0, s_reg.delay})) begin
                    s_next.motor_on = 1'b0;
                    s_next.st = brake_seq_pkg::ST_OFF;
                end
            end
            brake_seq_pkg::ST_RUN_WAIT: begin
                // Motor off, brake waits for speed or timeout
                if (stopped ||
                    (tick && ticks_inc >= s_reg.timeout)) begin
                    s_next.brake_rel = 1'b0;
                    s_next.st = brake_seq_pkg::ST_OFF;
                end
            end
            default: begin
                s_next.st = brake_seq_pkg::ST_OFF;
                s_next.motor_on = 1'b0;
                s_next.brake_rel = 1'b0;
            end
        endcase
        // Each circuit ORs the brake with other assigned signals
        for (int i = 0; i < brake_seq_pkg::NUM_CIRCUITS; i++) begin
            s_next.circ_n[i] = ~(other_out_on[i] |
                (s_next.brake_rel &&
                 s_reg.sel == 2'(i + 1)));
        end
        // Register writes; delay, level and timeout clamped to their setting ranges
        if (wr) begin
            case (paddr)
                brake_seq_pkg::OFS_OUT_SELECT: begin
                    s_next.sel = pwdata[brake_seq_pkg::SEL_MSB:
                                        brake_seq_pkg::SEL_LSB];
                end
                brake_seq_pkg::OFS_STAND_DELAY: begin
                    s_next.delay = (pwdata[5:0] > brake_seq_pkg::DELAY_MAX
                        || pwdata[31:6] != 26'h0) ?
                        brake_seq_pkg::DELAY_MAX : pwdata[5:0];
                end
                brake_seq_pkg::OFS_SPEED_LEVEL: begin
                    s_next.level = (pwdata[13:0] >
                        brake_seq_pkg::SPEED_SET_MAX ||
                        pwdata[31:14] != 18'h0) ?
                        brake_seq_pkg::SPEED_SET_MAX : pwdata[13:0];
                end
                brake_seq_pkg::OFS_TIMEOUT: begin
                    if (pwdata[6:0] > brake_seq_pkg::TIMEOUT_MAX ||
                        pwdata[31:7] != 25'h0) begin
                        s_next.timeout = brake_seq_pkg::TIMEOUT_MAX;
                    end else if (pwdata[6:0] <
                        brake_seq_pkg::TIMEOUT_MIN) begin
                        s_next.timeout = brake_seq_pkg::TIMEOUT_MIN;
                    end else begin
                        s_next.timeout = pwdata[6:0];
                    end
                end
                brake_seq_pkg::OFS_MAX_SPEED: begin
                    s_next.max_speed = pwdata[13:0];
                end
                default: begin
                    s_next.max_speed = s_reg.max_speed;
                end
            endcase
        end
        // Read data and error captured in the setup cycle
        if (psel && !penable) begin
            case (paddr)
                brake_seq_pkg::OFS_OUT_SELECT: begin
                    s_next.rdata[brake_seq_pkg::SEL_MSB:
                                 brake_seq_pkg::SEL_LSB] = s_reg.sel;
                end
                brake_seq_pkg::OFS_STAND_DELAY: begin
                    s_next.rdata[5:0] = s_reg.delay;
                end
                brake_seq_pkg::OFS_SPEED_LEVEL: begin
                    s_next.rdata[13:0] = s_reg.level;
                end
                brake_seq_pkg::OFS_TIMEOUT: begin
                    s_next.rdata[6:0] = s_reg.timeout;
                end
                brake_seq_pkg::OFS_MAX_SPEED: begin
                    s_next.rdata[13:0] = s_reg.max_speed;
                end
                brake_seq_pkg::OFS_STATUS: begin
                    s_next.rdata[brake_seq_pkg::STS_MOTOR_ON] =
                        s_reg.motor_on;
                    s_next.rdata[brake_seq_pkg::STS_BRAKE_REL] =
                        s_reg.brake_rel;
                    s_next.rdata[brake_seq_pkg::STS_ALARM] = s_reg.alarm;
                    s_next.rdata[brake_seq_pkg::STS_ENCODER] =
                        s_reg.encoder;
                    s_next.rdata[brake_seq_pkg::STS_CODE_LSB +: 3] =
                        s_reg.code;
                    s_next.rdata[brake_seq_pkg::STS_RUNNING] = ~stopped;
                end
                default: begin
                    s_next.err = 1'b1;
                end
            endcase
            if (pwrite && paddr == brake_seq_pkg::OFS_STATUS) begin
                s_next.err = 1'b1;
            end
        end else if (psel) begin
            s_next.rdata = s_reg.rdata;
            s_next.err = s_reg.err;
        end
    end

    // State register with documented defaults
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.st <= brake_seq_pkg::ST_OFF;
            s_reg.circ_n <= 3'h7;
            s_reg.sel <= brake_seq_pkg::SEL_RST;
            s_reg.delay <= brake_seq_pkg::DELAY_RST;
            s_reg.level <= brake_seq_pkg::SPEED_RST;
            s_reg.timeout <= brake_seq_pkg::TIMEOUT_RST;
            s_reg.max_speed <= brake_seq_pkg::MAX_SPEED_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops, pready tied high
    assign pready = 1'b1;
    assign prdata = s_reg.rdata;
    assign pslverr = s_reg.err;
    assign motor_power_on = s_reg.motor_on;
    assign brake_interlock_out = ~s_reg.brake_rel;
    assign out_circuit_n = s_reg.circ_n;
    assign alarm_status_out = s_reg.alarm;
    assign alarm_code_bit0 = s_reg.code[0];
    assign alarm_code_bit1 = s_reg.code[1];
    assign alarm_code_bit2 = s_reg.code[2];

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    on_released_a: assert property (
        s_reg.st == brake_seq_pkg::ST_ON |-> !brake_interlock_out)
        else $error("brake not released while on");
    unrouted_a: assert property (
        s_reg.sel == 2'h0 && other_out_on == 3'h0 |=> out_circuit_n == 3'h7)
        else $error("unrouted brake reached a circuit");
    or_merge_a: assert property (
        other_out_on[1] |=> !out_circuit_n[1])
        else $error("other signal lost on shared circuit");
    zero_delay_a: assert property (
        s_reg.st == brake_seq_pkg::ST_ON && !son && stopped &&
        s_reg.delay == 6'h00 && !alarm_detect && !s_reg.alarm
        |=> !motor_power_on && brake_interlock_out)
        else $error("motor and brake not switched together");
    stand_hold_a: assert property (
        s_reg.st == brake_seq_pkg::ST_STAND_WAIT
        |-> motor_power_on && brake_interlock_out)
        else $error("standstill delay state broken");
    speed_brake_a: assert property (
        s_reg.st == brake_seq_pkg::ST_RUN_WAIT && stopped
        |=> brake_interlock_out && !motor_power_on)
        else $error("brake late below speed level");
    alarm_off_a: assert property (
        alarm_detect |=> !motor_power_on ##0 alarm_status_out)
        else $error("alarm did not stop motor");
    code_latch_a: assert property (
        alarm_detect && !s_reg.alarm |=>
        {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0} ==
        $past(alarm_type))
        else $error("alarm code not latched");
    encoder_hold_a: assert property (
        s_reg.alarm && s_reg.encoder && clr_edge |=> alarm_status_out)
        else $error("encoder alarm cleared by input");
    clear_a: assert property (
        s_reg.alarm && !s_reg.encoder && clr_edge && !alarm_detect
        |=> !alarm_status_out)
        else $error("alarm not cleared");

    stand_seq_c: cover property (
        s_reg.st == brake_seq_pkg::ST_STAND_WAIT ##1
        s_reg.st == brake_seq_pkg::ST_OFF);
    run_seq_c: cover property (
        s_reg.st == brake_seq_pkg::ST_RUN_WAIT ##1
        s_reg.st == brake_seq_pkg::ST_OFF);
    alarm_clear_c: cover property (
        alarm_status_out ##1 !alarm_status_out);
endmodule

// ---- design/sync2.sv ----
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clock,         // System clock
    input wire logic arst_n,        // Asynchronous reset, active low
    input wire logic [W-1:0] d,     // Asynchronous levels
    output logic [W-1:0] q          // Synchronised levels
);
    // First and second stage; only the second stage reads the first
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // Shift the pin level through both stages
    always_comb begin
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    // Both stages start from the inactive level
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= {RESET_VAL, RESET_VAL};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stable;
endmodule

// ---- design/tick_gen.sv ----
// Restartable time-base tick generator
`timescale 1ns/1ns
module tick_gen #(
    parameter int CYCLES = 1250000
) (
    input wire logic clock,         // System clock
    input wire logic arst_n,        // Asynchronous reset, active low
    input wire logic restart,       // Realign the time base to now
    output logic tick               // One-cycle pulse per period
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    // Cycle counter and registered tick
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_reg;
    tick_state_t s_next;

    // Count cycles; a restart begins a fresh full period
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (restart) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt == LAST) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + CW'(1);
        end
    end

    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// ---- pkg/brake_seq_pkg.sv ----
// Constants shared by the brake interlock and alarm sequencer
package brake_seq_pkg;
    // Time base: 10 ms tick derived from the 125 MHz clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_MS = 10;
    localparam int TICK_PERIOD_NS = TICK_PERIOD_MS * 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // APB byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_OUT_SELECT = 8'h00;
    localparam logic [7:0] OFS_STAND_DELAY = 8'h04;
    localparam logic [7:0] OFS_SPEED_LEVEL = 8'h08;
    localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
    localparam logic [7:0] OFS_MAX_SPEED = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // Field widths and positions
    localparam int SEL_LSB = 8;
    localparam int SEL_MSB = 9;
    localparam int DELAY_W = 6;
    localparam int SPEED_W = 14;
    localparam int TIMEOUT_W = 7;
    localparam int CODE_W = 3;
    localparam int NUM_CIRCUITS = 3;

    // Status register bit positions
    localparam int STS_MOTOR_ON = 0;
    localparam int STS_BRAKE_REL = 1;
    localparam int STS_ALARM = 2;
    localparam int STS_ENCODER = 3;
    localparam int STS_CODE_LSB = 4;
    localparam int STS_RUNNING = 7;

    // Reset values and setting limits
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [5:0] DELAY_RST = 6'h00;
    localparam logic [5:0] DELAY_MAX = 6'h32;
    localparam logic [13:0] SPEED_RST = 14'h0064;
    localparam logic [13:0] SPEED_SET_MAX = 14'h2710;
    localparam logic [13:0] MAX_SPEED_RST = 14'h0BB8;
    localparam logic [6:0] TIMEOUT_RST = 7'h32;
    localparam logic [6:0] TIMEOUT_MIN = 7'h0A;
    localparam logic [6:0] TIMEOUT_MAX = 7'h64;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_STAND_WAIT,
        ST_RUN_WAIT
    } seq_state_t;
endpackage

// ---- testbench/brake_interlock_alarm_sequencer_tb.sv ----
// Self-checking bench for the brake and alarm sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
$display("Error %0t: got %0h want %0h", $time, a, b); end end
module brake_interlock_alarm_sequencer_tb;
    localparam int TK = 10; // Short tick for simulation
    logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, seed = 32'h48c9;
    logic pready, pslverr, e, servo_on_n, servo_req = 0;
    logic alarm_clear_in = 0, alarm_detect = 0, alarm_is_encoder = 0;
    logic [13:0] motor_speed = 0;
    logic [2:0] alarm_type = 0, other_out_on = 0, oth, t;
    logic motor_power_on, brake_interlock_out, alarm_status_out;
    logic alarm_code_bit0, alarm_code_bit1, alarm_code_bit2;
    logic [2:0] out_circuit_n;
    int miscompares = 0, n_checks = 0, n, d;
    // Clock at 8 ns
    always #4 clock = ~clock;
    brake_alarm_seq #(.TICK_CYCLES(TK)) dut_u (.clock, .arst_n, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .servo_on_n, .alarm_clear_in, .motor_speed, .alarm_detect,
        .alarm_type, .alarm_is_encoder, .other_out_on, .motor_power_on,
        .brake_interlock_out, .out_circuit_n, .alarm_status_out,
        .alarm_code_bit0, .alarm_code_bit1, .alarm_code_bit2);
    host_model host_u (.clock, .arst_n, .servo_req, .alarm_status_out,
        .servo_on_n);
    // Random source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected circuit levels, low closed
    function automatic logic [2:0] circ(int s, logic bk, logic [2:0] o);
        logic [2:0] m;
        m = (bk && s != 0) ? 3'h1 << (s - 1) : 3'h0;
        return ~(o | m);
    endfunction
    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // Count edges until an output reaches a level
    task automatic until_out(input int mot, input logic lvl);
        n = 0;
        while ((mot ? motor_power_on : brake_interlock_out) !== lvl) begin
            @(posedge clock);
            n++;
        end
    endtask
    // Servo on then off, returns edges from the off request to brake applied
    task automatic cycle_servo(input logic [13:0] spd);
        servo_req <= 1'b1;
        until_out(0, 1'b0);
        motor_speed <= spd;
        repeat (2) @(posedge clock);
        servo_req <= 1'b0;
        until_out(0, 1'b1);
    endtask
    // Verdict
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        `CHK(brake_interlock_out, 1'b1)
        `CHK(out_circuit_n, 3'h7)
        @(posedge clock);
        apb(0, 8'h00, 0);
        `CHK(r[9:8], 2'h0)
        apb(0, 8'h08, 0);
        `CHK(r[13:0], 14'h0064)
        apb(0, 8'h0C, 0);
        `CHK(r[6:0], 7'h32)
        apb(0, 8'hFC, 0);
        `CHK(e, 1'b1)
        apb(1, 8'h04, 32'h0000003F);
        apb(0, 8'h04, 0);
        `CHK(r[5:0], 6'h32)
        apb(1, 8'h04, 0);
        for (int s = 0; s < 4; s++) begin
            apb(1, 8'h00, s << 8);
            oth = 3'(rnd());
            other_out_on <= oth;
            servo_req <= 1'b1;
            until_out(0, 1'b0);
            repeat (3) @(posedge clock);
            `CHK(out_circuit_n, circ(s, 1, oth))
            `CHK(motor_power_on, 1'b1)
            servo_req <= 1'b0;
            until_out(0, 1'b1);
            `CHK(motor_power_on, 1'b0)
            repeat (3) @(posedge clock);
            `CHK(out_circuit_n, circ(s, 0, oth))
        end
        d = 1 + rnd() % 3;
        apb(1, 8'h04, d);
        cycle_servo(0);
        until_out(1, 1'b0);
        `CHK(n >= d * TK && n <= d * TK + 3, 1'b1)
        apb(1, 8'h04, 0);
        apb(1, 8'h0C, 32'h0000000A);
        cycle_servo(500);
        `CHK(motor_power_on, 1'b0)
        // Counted from the request: host, two sync stages, tick alignment
        `CHK(n >= 10 * TK + 5 && n <= 10 * TK + 7, 1'b1)
        servo_req <= 1'b1;
        until_out(0, 1'b0);
        servo_req <= 1'b0;
        repeat (30) @(posedge clock);
        motor_speed <= 14'h0014;
        until_out(0, 1'b1);
        `CHK(n <= 4, 1'b1)
        apb(1, 8'h10, 32'h00000032);
        motor_speed <= 14'h0046;
        apb(0, 8'h14, 0);
        `CHK(r[7], 1'b1)
        motor_speed <= 0;
        for (int enc = 0; enc < 2; enc++) begin
            servo_req <= 1'b1;
            until_out(1, 1'b1);
            t = 3'(rnd());
            alarm_type <= t;
            alarm_is_encoder <= enc[0];
            alarm_detect <= 1'b1;
            @(posedge clock);
            alarm_detect <= 1'b0;
            @(negedge clock);
            `CHK(alarm_status_out, 1'b1)
            `CHK({alarm_code_bit2, alarm_code_bit1, alarm_code_bit0}, t)
            `CHK(motor_power_on, 1'b0)
            @(posedge clock);
            alarm_clear_in <= 1'b1;
            repeat (6) @(posedge clock);
            alarm_clear_in <= 1'b0;
            @(negedge clock);
            `CHK(alarm_status_out, enc[0])
            @(posedge clock);
        end
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock);
        `CHK(alarm_status_out, 1'b0)
        end_of_test();
    end
endmodule

// ---- testbench/host_model.sv ----
// Host controller model that drives the servo-on pin
`timescale 1ns/1ns
module host_model (
    input wire logic clock, // System clock
    input wire logic arst_n, // Reset, active low
    input wire logic servo_req, // Bench asks for servo on
    input wire logic alarm_status_out, // Alarm level from drive
    output logic servo_on_n // Servo-on pin, low = on
);
    // Servo-on is withdrawn while the drive reports an alarm
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            servo_on_n <= 1'b1;
        end else begin
            servo_on_n <= ~(servo_req & ~alarm_status_out);
        end
    end
endmodule
